/* File: src/free_running_capture_timer.sv */
// Free-running counter, two edge capture channels and interval counter behind APB.
// Function
// - 16-bit free counter, low read latches high.
// - Snapshot taken when low byte is read.
// - Counter write applied at high-byte write.
// - Channel 0 rising edge stores counter value.
// - Channel 0 falling edge stores counter value.
// - Channel 1 rising edge captures unless widened.
// - Channel 1 falling edge captures unless widened.
// - Prescale code picks captured bits in 8-bit.
// - Wide mode: channel 0 holds low byte.
// - Wide mode: channel 1 rising gets high byte.
// - Wide mode: channel 1 falling gets high byte.
// - 12-bit interval counter, low read latches nibble.
// - Register accesses cross into timer logic safely.
// - Code n selects counter bits n+7 to n.
// - First-edge hold keeps value until read.
// - Wide enable disables channel 1 captures.
// - Per-event interrupt enables gate requests.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "capture_timer_params.svh"
module free_running_capture_timer
#(
	parameter logic [11:0] PIT_RELOAD = `PIT_RELOAD_DEFAULT
)
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capture_in_zero,
	input  wire logic        capture_in_one,
	output logic      [3:0]  capture_irq
);

	capture_timer_pkg::apb_state_t state_r;
	capture_timer_pkg::apb_state_t state_nxt;

	logic [31:0]                  prdata_r;
	logic [31:0]                  prdata_nxt;
	logic                         pready_r;
	logic                         pready_nxt;
	logic                         pslverr_r;
	logic                         pslverr_nxt;
	logic                         rd_now;
	logic                         wr_now;
	logic                         hit_any;
	capture_timer_pkg::byte_t     rd_byte;

	logic [15:0]                  frt_r;
	logic [15:0]                  frt_nxt;
	capture_timer_pkg::byte_t     frt_stage_r;
	capture_timer_pkg::byte_t     frt_stage_nxt;
	capture_timer_pkg::byte_t     frt_hold_r;
	capture_timer_pkg::byte_t     frt_hold_nxt;
	logic [11:0]                  pit_r;
	logic [11:0]                  pit_nxt;
	logic [3:0]                   pit_hold_r;
	logic [3:0]                   pit_hold_nxt;

	capture_timer_pkg::byte_t     cfg_r;
	capture_timer_pkg::byte_t     cfg_nxt;
	logic [3:0]                   int_en_r;
	logic [3:0]                   int_en_nxt;
	logic [3:0]                   irq_r;
	logic [3:0]                   irq_nxt;

	capture_timer_pkg::byte_t     cap_r [0:3];
	capture_timer_pkg::byte_t     cap_nxt [0:3];
	logic [3:0]                   held_r;
	logic [3:0]                   held_nxt;
	logic [3:0]                   cap_ev;
	logic [3:0]                   cap_rd;
	logic [3:0]                   cap_wr;
	capture_timer_pkg::byte_t     cap_val [0:3];
	capture_timer_pkg::byte_t     window;
	logic                         wide;
	logic                         hold_en;
	logic [2:0]                   presc;

	edge_event_if ev_zero ();
	edge_event_if ev_one ();

	capture_edge_detect u_edge_zero
	(
		.core_clk (core_clk),
		.reset    (reset),
		.pin_in   (capture_in_zero),
		.ev       (ev_zero)
	);

	capture_edge_detect u_edge_one
	(
		.core_clk (core_clk),
		.reset    (reset),
		.pin_in   (capture_in_one),
		.ev       (ev_one)
	);

	function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
		hit = (addr == {2'h0, idx, 2'h0});
	endfunction : hit

	assign wide    = cfg_r[`CFG_WIDE_BIT];
	assign hold_en = cfg_r[`CFG_HOLD_BIT];
	assign presc   = cfg_r[`CFG_PRESC_MSB:`CFG_PRESC_LSB];

	// Decodes the address and selects the byte that a read returns.
	always_comb
	begin
		hit_any = 1'b1;
		rd_byte = `REG_RESET_BYTE;
		case (paddr)
			{2'h0, `FRT_LOW_IDX, 2'h0}:    rd_byte = frt_r[7:0];
			{2'h0, `FRT_HIGH_IDX, 2'h0}:   rd_byte = frt_hold_r;
			{2'h0, `CAP0_RISE_IDX, 2'h0}:  rd_byte = cap_r[0];
			{2'h0, `CAP1_RISE_IDX, 2'h0}:  rd_byte = cap_r[1];
			{2'h0, `CAP0_FALL_IDX, 2'h0}:  rd_byte = cap_r[2];
			{2'h0, `CAP1_FALL_IDX, 2'h0}:  rd_byte = cap_r[3];
			{2'h0, `PIT_LOW_IDX, 2'h0}:    rd_byte = pit_r[7:0];
			{2'h0, `PIT_HIGH_IDX, 2'h0}:   rd_byte = {4'h0, pit_hold_r};
			{2'h0, `TIMER_CFG_IDX, 2'h0}:  rd_byte = {cfg_r[7:3], 3'h0};
			{2'h0, `CAP_INT_EN_IDX, 2'h0}: rd_byte = {4'h0, int_en_r};
			default:                       hit_any = 1'b0;
		endcase
	end

	// Register accesses are staged so timer state changes on one clean edge each.
	always_comb
	begin
		state_nxt   = state_r;
		pready_nxt  = 1'b0;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		rd_now      = 1'b0;
		wr_now      = 1'b0;
		case (state_r)
			capture_timer_pkg::ST_IDLE:
			begin
				if (psel && penable)
				begin
					state_nxt   = capture_timer_pkg::ST_ANSWER;
					pready_nxt  = 1'b1;
					pslverr_nxt = ~hit_any;
					rd_now      = ~pwrite & hit_any;
					prdata_nxt  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				end
			end
			capture_timer_pkg::ST_ANSWER:
			begin
				state_nxt = capture_timer_pkg::ST_IDLE;
				wr_now    = psel & penable & pwrite & pstrb[0] & hit_any;
			end
			default:
			begin
				state_nxt = capture_timer_pkg::ST_IDLE;
			end
		endcase
	end

	// Free-running and interval counters with their holding registers.
	always_comb
	begin
		frt_nxt       = frt_r + 16'h0001;
		frt_stage_nxt = frt_stage_r;
		frt_hold_nxt  = frt_hold_r;
		pit_nxt       = (pit_r == 12'h000) ? PIT_RELOAD : pit_r - 12'h001;
		pit_hold_nxt  = pit_hold_r;
		if (rd_now && hit(paddr, `FRT_LOW_IDX))
		begin
			frt_hold_nxt = frt_r[15:8];
		end
		if (rd_now && hit(paddr, `PIT_LOW_IDX))
		begin
			pit_hold_nxt = pit_r[11:8];
		end
		if (wr_now && hit(paddr, `FRT_LOW_IDX))
		begin
			frt_stage_nxt = pwdata[7:0];
		end
		if (wr_now && hit(paddr, `FRT_HIGH_IDX))
		begin
			frt_nxt = {pwdata[7:0], frt_stage_r};
		end
	end

	// Configuration, interrupt enables and gated capture requests.
	always_comb
	begin
		cfg_nxt    = cfg_r;
		int_en_nxt = int_en_r;
		if (wr_now && hit(paddr, `TIMER_CFG_IDX))
		begin
			cfg_nxt = {pwdata[7:3], 3'h0};
		end
		if (wr_now && hit(paddr, `CAP_INT_EN_IDX))
		begin
			int_en_nxt = pwdata[3:0];
		end
		irq_nxt[0] = ev_zero.rise & int_en_r[0];
		irq_nxt[1] = ev_zero.fall & int_en_r[1];
		irq_nxt[2] = ev_one.rise & ~wide & int_en_r[2];
		irq_nxt[3] = ev_one.fall & ~wide & int_en_r[3];
	end

	// Capture registers: 0 and 2 serve channel 0, 1 and 3 serve channel 1, or channel 0 in wide mode.
	always_comb
	begin
		window     = 8'(frt_r >> presc);
		cap_ev[0]  = ev_zero.rise;
		cap_ev[2]  = ev_zero.fall;
		cap_ev[1]  = wide ? ev_zero.rise : ev_one.rise;
		cap_ev[3]  = wide ? ev_zero.fall : ev_one.fall;
		cap_val[0] = wide ? frt_r[7:0] : window;
		cap_val[2] = wide ? frt_r[7:0] : window;
		cap_val[1] = wide ? frt_r[15:8] : window;
		cap_val[3] = wide ? frt_r[15:8] : window;
		for (int i = 0; i < 4; i++)
		begin
			cap_rd[i] = rd_now && hit(paddr, 8'(`CAP0_RISE_IDX + i));
			cap_wr[i] = wr_now && hit(paddr, 8'(`CAP0_RISE_IDX + i));
			if (cap_ev[i] && (!hold_en || !held_r[i] || cap_rd[i]))
			begin
				cap_nxt[i]  = cap_val[i];
				held_nxt[i] = 1'b1;
			end
			else
			begin
				cap_nxt[i]  = cap_wr[i] ? pwdata[7:0] : cap_r[i];
				held_nxt[i] = (cap_rd[i] || cap_wr[i]) ? 1'b0 : held_r[i];
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_r     <= capture_timer_pkg::ST_IDLE;
			prdata_r    <= 32'h0000_0000;
			pready_r    <= 1'b0;
			pslverr_r   <= 1'b0;
			frt_r       <= `FRT_RESET;
			frt_stage_r <= `REG_RESET_BYTE;
			frt_hold_r  <= `REG_RESET_BYTE;
			pit_r       <= `PIT_RESET;
			pit_hold_r  <= 4'h0;
			cfg_r       <= `REG_RESET_BYTE;
			int_en_r    <= 4'h0;
			irq_r       <= 4'h0;
			held_r      <= 4'h0;
			for (int i = 0; i < 4; i++)
			begin
				cap_r[i] <= `REG_RESET_BYTE;
			end
		end
		else
		begin
			state_r     <= state_nxt;
			prdata_r    <= prdata_nxt;
			pready_r    <= pready_nxt;
			pslverr_r   <= pslverr_nxt;
			frt_r       <= frt_nxt;
			frt_stage_r <= frt_stage_nxt;
			frt_hold_r  <= frt_hold_nxt;
			pit_r       <= pit_nxt;
			pit_hold_r  <= pit_hold_nxt;
			cfg_r       <= cfg_nxt;
			int_en_r    <= int_en_nxt;
			irq_r       <= irq_nxt;
			held_r      <= held_nxt;
			for (int i = 0; i < 4; i++)
			begin
				cap_r[i] <= cap_nxt[i];
			end
		end
	end

	assign prdata      = prdata_r;
	assign pready      = pready_r;
	assign pslverr     = pslverr_r;
	assign capture_irq = irq_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	logic frt_hi_wr;
	assign frt_hi_wr = wr_now && hit(paddr, `FRT_HIGH_IDX);

	frt_count_a: assert property ((!reset && !frt_hi_wr)
		|=> frt_r == 16'($past(frt_r) + 16'h0001))
		else $error("Free counter did not advance by one.");
	low_snapshot_a: assert property ((rd_now && hit(paddr, `FRT_LOW_IDX))
		|=> frt_hold_r == $past(frt_r[15:8]) && prdata_r[7:0] == $past(frt_r[7:0]))
		else $error("Low byte read did not snapshot the high byte.");
	frt_write_a: assert property (frt_hi_wr
		|=> frt_r == {$past(pwdata[7:0]), $past(frt_stage_r)})
		else $error("High byte write did not load the counter.");
	pit_latch_a: assert property ((rd_now && hit(paddr, `PIT_LOW_IDX))
		|=> pit_hold_r == $past(pit_r[11:8]))
		else $error("Interval low read did not latch the nibble.");
	cap_window_a: assert property ((ev_zero.rise && !wide && !hold_en)
		|=> cap_r[0] == 8'($past(frt_r) >> $past(presc)))
		else $error("Channel 0 rising capture holds wrong bits.");
	wide_upper_a: assert property ((ev_zero.fall && wide && !hold_en)
		|=> cap_r[3] == $past(frt_r[15:8]) && cap_r[2] == $past(frt_r[7:0]))
		else $error("Wide falling capture split the counter wrongly.");
	first_hold_a: assert property ((hold_en && held_r[0] && !cap_rd[0] && !cap_wr[0])
		|=> $stable(cap_r[0]))
		else $error("Held capture was overwritten before a read.");
	ch1_off_a: assert property ((wide && !ev_zero.rise && !cap_wr[1])
		|=> $stable(cap_r[1]))
		else $error("Channel 1 captured while widened.");
	irq_gate_a: assert property (irq_r[2] |-> $past(int_en_r[2]) && !$past(wide))
		else $error("Interrupt request raised without its enable.");
	answer_time_a: assert property ((psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
		else $error("Slave answer not one cycle long.");

	wide_cov_c: cover property (wide && ev_zero.rise);
	hold_cov_c: cover property (hold_en && held_r[0] && ev_zero.rise);
	snap_cov_c: cover property ((rd_now && hit(paddr, `FRT_LOW_IDX)) ##[1:20] frt_hi_wr);
	irq_cov_c: cover property (irq_r[3]);

endmodule : free_running_capture_timer

/* File: src/capture_timer_params.svh */
// Register indices, field positions and reset values of the capture timer.
`ifndef CAPTURE_TIMER_PARAMS_SVH
`define CAPTURE_TIMER_PARAMS_SVH

`define FRT_LOW_IDX        8'h20
`define FRT_HIGH_IDX       8'h21
`define CAP0_RISE_IDX      8'h22
`define CAP1_RISE_IDX      8'h23
`define CAP0_FALL_IDX      8'h24
`define CAP1_FALL_IDX      8'h25
`define PIT_LOW_IDX        8'h26
`define PIT_HIGH_IDX       8'h27
`define TIMER_CFG_IDX      8'h2a
`define CAP_INT_EN_IDX     8'h2b

`define CFG_HOLD_BIT       7
`define CFG_PRESC_MSB      6
`define CFG_PRESC_LSB      4
`define CFG_WIDE_BIT       3

`define REG_RESET_BYTE     8'h00
`define FRT_RESET          16'h0000
`define PIT_RESET          12'h000
`define PIT_RELOAD_DEFAULT 12'hfff

`endif

/* File: src/capture_timer_pkg.sv */
// Types shared by the capture timer modules.
package capture_timer_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [1:0]
	{
		ST_IDLE   = 2'b01,
		ST_ANSWER = 2'b10
	} apb_state_t;

endpackage : capture_timer_pkg

/* File: src/edge_event_if.sv */
// Edge events passed from an input synchroniser to the capture logic.
`timescale 1ns/1ps
interface edge_event_if;
	logic rise;
	logic fall;

	modport src
	(
		output rise,
		output fall
	);

	modport dst
	(
		input  rise,
		input  fall
	);
endinterface : edge_event_if

/* File: src/capture_edge_detect.sv */
// Synchroniser and edge detector for one capture input pin.
`timescale 1ns/1ps
module capture_edge_detect
(
	input  wire logic   core_clk,
	input  wire logic   reset,
	input  wire logic   pin_in,
	edge_event_if.src   ev
);

	logic sync1_r;
	logic sync2_r;
	logic last_r;
	logic rise_r;
	logic fall_r;
	logic rise_nxt;
	logic fall_nxt;

	always_comb
	begin
		rise_nxt = sync2_r & ~last_r;
		fall_nxt = ~sync2_r & last_r;
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			last_r  <= 1'b0;
			rise_r  <= 1'b0;
			fall_r  <= 1'b0;
		end
		else
		begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			last_r  <= sync2_r;
			rise_r  <= rise_nxt;
			fall_r  <= fall_nxt;
		end
	end

	assign ev.rise = rise_r;
	assign ev.fall = fall_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	one_capture_a: assert property (ev.rise |=> !ev.rise)
		else $error("Rising edge event lasted more than one cycle.");
	edge_follows_a: assert property ($rose(sync2_r) |=> ev.rise)
		else $error("Synchronised rising edge gave no event.");

endmodule : capture_edge_detect

/* File: tb/capture_pin_driver.sv */
// Model of the external edge sources on the two capture pins.
`timescale 1ns/1ps
module capture_pin_driver
(
	input  wire logic core_clk,
	output logic      pin_zero,
	output logic      pin_one
);
	initial
	begin
		pin_zero = 1'b0;
		pin_one  = 1'b0;
	end

	// Holds one pin high for n clocks, then leaves time for the capture to land.
	task automatic pulse(input int ch, input int n);
		@(posedge core_clk);
		if (ch == 0)
			pin_zero <= 1'b1;
		else
			pin_one <= 1'b1;
		repeat (n) @(posedge core_clk);
		if (ch == 0)
			pin_zero <= 1'b0;
		else
			pin_one <= 1'b0;
		repeat (12) @(posedge core_clk);
	endtask : pulse
endmodule : capture_pin_driver

/* File: tb/free_running_capture_timer_tb.sv */
// Self-checking testbench of the capture timer over APB.
`timescale 1ns/1ps
`include "capture_timer_params.svh"
module free_running_capture_timer_tb;
	logic        core_clk;
	logic        reset;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin_zero;
	logic        pin_one;
	logic [3:0]  capture_irq;
	logic [31:0] rdat;
	logic        rerr;
	logic [15:0] a;
	logic [15:0] b;
	int          miscompares;
	int          samples_checked;
	int          irq_cnt[4];
	int          irq_exp[4];

	free_running_capture_timer #(.PIT_RELOAD(12'h100)) free_running_capture_timer_i
	(
		.core_clk        (core_clk),
		.reset           (reset),
		.paddr           (paddr),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.pwdata          (pwdata),
		.pstrb           (pstrb),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.capture_in_zero (pin_zero),
		.capture_in_one  (pin_one),
		.capture_irq     (capture_irq)
	);

	capture_pin_driver capture_pin_driver_i
	(
		.core_clk (core_clk),
		.pin_zero (pin_zero),
		.pin_one  (pin_one)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
		if (!reset)
			for (int i = 0; i < 4; i++)
				irq_cnt[i] += (capture_irq[i] === 1'b1);

	task complete_run;
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic check_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		samples_checked++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h outside %h..%h", $time, got, lo, hi);
		end
	endtask : check_rng

	// One APB transfer; the request is held until pready is sampled high.
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h0, d};
		pstrb   <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d, 4'hf);
	endtask : wr

	task automatic rd(input logic [7:0] idx);
		xfer(1'b0, idx, 8'h00, 4'h0);
	endtask : rd

	// Pulses a pin for n clocks and checks the fall minus rise capture.
	task automatic cap8(input int ch, input int n, input logic [7:0] ri, input logic [7:0] fi,
		input logic [7:0] exp);
		capture_pin_driver_i.pulse(ch, n);
		rd(ri);
		a[7:0] = rdat[7:0];
		rd(fi);
		check({8'h00, 8'(rdat[7:0] - a[7:0])}, {8'h00, exp});
	endtask : cap8

	initial
	begin
		#(100 * 40000);
		miscompares++;
		complete_run();
	end

	initial
	begin
		reset   = 1'b1;
		paddr   = 12'h000;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		pwdata  = 32'h0;
		pstrb   = 4'h0;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		for (int i = 2; i < 6; i++)
		begin
			rd(8'h20 + 8'(i));
			check(rdat[15:0], 16'h0000);
		end
		rd(8'h2c);
		check({15'h0, rerr}, 16'h0001);
		xfer(1'b1, `TIMER_CFG_IDX, 8'h08, 4'h0);
		rd(`TIMER_CFG_IDX);
		check(rdat[15:0], 16'h0000);
		wr(`CAP1_FALL_IDX, 8'h5a);
		rd(`CAP1_FALL_IDX);
		check(rdat[15:0], 16'h005a);
		wr(`FRT_LOW_IDX, 8'hfe);
		repeat (50) @(posedge core_clk);
		wr(`FRT_HIGH_IDX, 8'h12);
		rd(`FRT_LOW_IDX);
		a[7:0] = rdat[7:0];
		repeat (300) @(posedge core_clk);
		rd(`FRT_HIGH_IDX);
		a[15:8] = rdat[7:0];
		check_rng(a, 16'h12ff, 16'h130e);
		for (int i = 0; i < 4; i++)
		begin
			rd(`PIT_LOW_IDX);
			a[7:0] = rdat[7:0];
			repeat (i * 37) @(posedge core_clk);
			rd(`PIT_HIGH_IDX);
			a[15:8] = rdat[7:0];
			check_rng(a, 16'h0000, 16'h0100);
		end
		wr(`CAP_INT_EN_IDX, 8'h0f);
		wr(`TIMER_CFG_IDX, 8'h00);
		cap8(0, 40, `CAP0_RISE_IDX, `CAP0_FALL_IDX, 8'd40);
		cap8(1, 50, `CAP1_RISE_IDX, `CAP1_FALL_IDX, 8'd50);
		wr(`CAP_INT_EN_IDX, 8'h05);
		cap8(0, 30, `CAP0_RISE_IDX, `CAP0_FALL_IDX, 8'd30);
		for (int p = 0; p < 8; p++)
		begin
			wr(`TIMER_CFG_IDX, {1'b0, 3'(p), 4'h0});
			cap8(1, 3 << p, `CAP1_RISE_IDX, `CAP1_FALL_IDX, 8'd3);
		end
		wr(`CAP_INT_EN_IDX, 8'h0f);
		wr(`TIMER_CFG_IDX, 8'h78);
		capture_pin_driver_i.pulse(0, 300);
		rd(`CAP0_RISE_IDX);
		a[7:0] = rdat[7:0];
		rd(`CAP1_RISE_IDX);
		a[15:8] = rdat[7:0];
		rd(`CAP0_FALL_IDX);
		b[7:0] = rdat[7:0];
		rd(`CAP1_FALL_IDX);
		b[15:8] = rdat[7:0];
		check(b - a, 16'd300);
		capture_pin_driver_i.pulse(1, 20);
		rd(`CAP1_RISE_IDX);
		check({8'h00, rdat[7:0]}, {8'h00, a[15:8]});
		irq_exp = '{3, 2, 9, 1};
		for (int i = 0; i < 4; i++)
			check(16'(irq_cnt[i]), 16'(irq_exp[i]));
		wr(`TIMER_CFG_IDX, 8'h80);
		rd(`CAP0_RISE_IDX);
		rd(`CAP0_FALL_IDX);
		capture_pin_driver_i.pulse(0, 20);
		cap8(0, 60, `CAP0_RISE_IDX, `CAP0_FALL_IDX, 8'd20);
		cap8(0, 60, `CAP0_RISE_IDX, `CAP0_FALL_IDX, 8'd60);
		complete_run();
	end
endmodule : free_running_capture_timer_tb
